// >>> spc_pkg.sv
// spc_pkg.sv - shared constants and types of the serial port config block
// assumes one system clock at 200 MHz and a serial clock from the host
package spc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // address and frame geometry
    localparam int ADDR_W = 15;
    localparam int INSTR_BITS = 16;
    localparam int BYTE_BITS = 8;
    localparam int RW_BIT = 15;
    localparam int NUM_BUF_DEF = 4;

    // register offsets
    localparam logic [ADDR_W-1:0] CFG_A_ADDR = 15'h0000;
    localparam logic [ADDR_W-1:0] CFG_B_ADDR = 15'h0001;
    localparam logic [ADDR_W-1:0] UPDATE_ADDR = 15'h000f;
    localparam logic [ADDR_W-1:0] BUF_BASE_ADDR = 15'h0010;

    // values after reset, and the write mask of configuration B
    localparam logic [7:0] CFG_A_RST = 8'h00;
    localparam logic [7:0] CFG_B_RST = 8'h00;
    localparam logic [7:0] BUF_RST = 8'h00;
    localparam logic [7:0] CFG_B_WR_MASK = 8'h24;

    // field positions, configuration A and its mirrors
    localparam int A_SOFT_RST = 7;
    localparam int A_LSB_FIRST = 6;
    localparam int A_ADDR_INC = 5;
    localparam int A_FOUR_WIRE = 4;
    localparam int A_FOUR_WIRE_M = 3;
    localparam int A_ADDR_INC_M = 2;
    localparam int A_LSB_FIRST_M = 1;
    localparam int A_SOFT_RST_M = 0;
    // field positions, configuration B and the update register
    localparam int B_READ_BUF = 5;
    localparam int B_KEEP_RST = 2;
    localparam int UPD_BIT = 0;

    // reset pulse length towards the core
    localparam int CLK_PERIOD_PS = 5000;
    localparam int RESET_HOLD_NS = 100;
    localparam int RESET_HOLD_CYC = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    ////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic spiOn;
        logic lsbFirst;
        logic addrInc;
        logic fourWire;
    } spc_port_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } spc_wr_word_t;

    typedef enum logic [1:0] {
        PH_INSTR = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ = 2'b10,
        PH_OFF = 2'b11
    } spc_phase_t;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_HOLD = 2'b01,
        RS_DONE = 2'b10
    } spc_rst_state_t;

    ////////////////////////////////////////////////////////////////////////
    // functions
    // each control acts only when it and its mirror agree
    function automatic spc_port_mode_t spc_mode_of(input logic [7:0] cfgA, input logic i2c);
        spc_port_mode_t m;
        m.spiOn = ~i2c;
        m.lsbFirst = cfgA[A_LSB_FIRST] & cfgA[A_LSB_FIRST_M] & ~i2c;
        m.addrInc = cfgA[A_ADDR_INC] & cfgA[A_ADDR_INC_M] & ~i2c;
        m.fourWire = cfgA[A_FOUR_WIRE] & cfgA[A_FOUR_WIRE_M] & ~i2c;
        return m;
    endfunction

    function automatic logic [7:0] spc_rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction

    function automatic logic [15:0] spc_rev16(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15-i];
        end
        return r;
    endfunction

endpackage

// >>> spc_sync.sv
// spc_sync.sv - two flip-flop level synchroniser of parameter width
// assumes each bit is a level, or a word held still while it crosses
`timescale 1ns/1ps
module spc_sync #(
    parameter int W = 1
) (
    // destination clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // crossing data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    import spc_pkg::*;

    typedef struct packed {
        logic [W-1:0] stage1;
        logic [W-1:0] stage2;
    } spc_sync_state_t;

    spc_sync_state_t sync_r;
    spc_sync_state_t sync_nxt;

    if (W < 1) begin : gBadWidth
        $error("spc_sync: width must be at least one");
    end

    // stage1 feeds stage2 only
    always_comb begin
        sync_nxt.stage1 = d;
        sync_nxt.stage2 = sync_r.stage1;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sync_r <= '0;
        end else begin
            sync_r <= sync_nxt;
        end
    end

    assign q = sync_r.stage2;
endmodule

// >>> spc_reset_seq.sv
// spc_reset_seq.sv - times the reset pulse handed to the core logic
// assumes startReq is held until done has been seen
`timescale 1ns/1ps
module spc_reset_seq #(
    parameter int HOLD_CYC = spc_pkg::RESET_HOLD_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // request and progress
    input wire logic startReq,
    output logic busy,
    output logic done
);
    import spc_pkg::*;

    typedef struct packed {
        spc_rst_state_t state;
        logic [15:0] cnt;
    } spc_seq_state_t;

    spc_seq_state_t seq_r;
    spc_seq_state_t seq_nxt;

    if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin : gBadHold
        $error("spc_reset_seq: HOLD_CYC out of range");
    end

    // idle, hold for HOLD_CYC cycles, one done cycle
    always_comb begin
        seq_nxt = seq_r;
        case (seq_r.state)
            RS_IDLE: begin
                seq_nxt.cnt = '0;
                if (startReq) begin
                    seq_nxt.state = RS_HOLD;
                end
            end
            RS_HOLD: begin
                seq_nxt.cnt = seq_r.cnt + 16'h0001;
                if (seq_r.cnt == 16'(HOLD_CYC - 1)) begin
                    seq_nxt.state = RS_DONE;
                end
            end
            RS_DONE: begin
                seq_nxt.state = RS_IDLE;
            end
            default: begin
                seq_nxt.state = RS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            seq_r <= '{state: RS_IDLE, cnt: 16'h0000};
        end else begin
            seq_r <= seq_nxt;
        end
    end

    // core stays in reset through the done cycle
    assign busy = (seq_r.state != RS_IDLE);
    assign done = (seq_r.state == RS_DONE);
endmodule

// >>> spc_config_top.sv
// spc_config_top.sv - serial port configuration registers and SPI engine
// assumes spiClk runs only while chipSel_b is low and stops between frames;
// the host keeps mirror bits equal to their partners.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module spc_config_top #(
    parameter int NUM_BUF = spc_pkg::NUM_BUF_DEF,
    parameter int HOLD_CYC = spc_pkg::RESET_HOLD_CYC
) (
    // system clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // serial port pins, link clock domain
    input wire logic spiClk,
    input wire logic chipSel_b,
    input wire logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    output logic sdoOut,
    output logic sdoOe,
    // port mode strap pin
    input wire logic i2cMode,
    // core side
    output logic [NUM_BUF-1:0][7:0] activeRegs,
    output spc_pkg::spc_port_mode_t portMode,
    output logic coreRst,
    output logic updateDone
);
    import spc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // slots of the register map
    localparam int SLOT_W = $clog2(NUM_BUF + 4);
    localparam logic [SLOT_W-1:0] SLOT_A = SLOT_W'(0);
    localparam logic [SLOT_W-1:0] SLOT_B = SLOT_W'(1);
    localparam logic [SLOT_W-1:0] SLOT_UPD = SLOT_W'(2);
    localparam logic [SLOT_W-1:0] SLOT_BUF0 = SLOT_W'(3);
    localparam logic [SLOT_W-1:0] SLOT_NONE = SLOT_W'(NUM_BUF + 3);

    if (NUM_BUF < 1 || NUM_BUF > 64) begin : gBadBuf
        $error("spc_config_top: NUM_BUF out of range");
    end

    // snapshot published from the system domain to the link domain
    typedef struct packed {
        spc_port_mode_t mode;
        logic [NUM_BUF-1:0][7:0] bufView;
        logic [7:0] cfgB;
        logic [7:0] cfgA;
    } spc_pub_t;

    // system domain state
    typedef struct packed {
        logic [7:0] cfgA;
        logic [7:0] cfgB;
        logic [NUM_BUF-1:0][7:0] bufShadow;
        logic [NUM_BUF-1:0][7:0] bufActive;
        logic fullRst;
        logic wrSeen;
        logic updPulse;
        spc_pub_t pub;
    } spc_sys_state_t;

    // link domain state, cleared by chip select
    typedef struct packed {
        spc_phase_t phase;
        logic [4:0] bitCnt;
        logic [15:0] shift;
        logic [ADDR_W-1:0] addr;
    } spc_frame_state_t;

    // link domain state that must outlive the frame
    typedef struct packed {
        logic wrToggle;
        spc_wr_word_t wrHold;
    } spc_hold_state_t;

    // falling edge output shifter
    typedef struct packed {
        logic [7:0] outShift;
        logic driving;
    } spc_drive_state_t;

    spc_sys_state_t sys_r;
    spc_sys_state_t sys_nxt;
    spc_frame_state_t frame_r;
    spc_frame_state_t frame_nxt;
    spc_hold_state_t hold_r;
    spc_hold_state_t hold_nxt;
    spc_drive_state_t drive_r;
    spc_drive_state_t drive_nxt;

    logic i2cSync;
    logic wrToggleSync;
    spc_pub_t pubSync;
    logic seqBusy;
    logic seqDone;
    logic softEff;
    logic resetReq;

    ////////////////////////////////////////////////////////////////////////////
    // functions
    // address to slot, shared by write and read paths
    function automatic logic [SLOT_W-1:0] slotOf(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] off;
        off = addr - BUF_BASE_ADDR;
        if (addr == CFG_A_ADDR) begin
            slotOf = SLOT_A;
        end else if (addr == CFG_B_ADDR) begin
            slotOf = SLOT_B;
        end else if (addr == UPDATE_ADDR) begin
            slotOf = SLOT_UPD;
        end else if (addr >= BUF_BASE_ADDR && off < ADDR_W'(NUM_BUF)) begin
            slotOf = SLOT_W'(off) + SLOT_BUF0;
        end else begin
            slotOf = SLOT_NONE;
        end
    endfunction

    // values after reset, also the image of a full soft reset
    function automatic spc_sys_state_t sysDefaults(input logic seen);
        spc_sys_state_t s;
        s = '0;
        s.cfgA = CFG_A_RST;
        s.cfgB = CFG_B_RST;
        for (int i = 0; i < NUM_BUF; i++) begin
            s.bufShadow[i] = BUF_RST;
            s.bufActive[i] = BUF_RST;
        end
        s.wrSeen = seen;
        return s;
    endfunction

    // update register and unmapped addresses read as zero
    function automatic logic [7:0] readOf(input spc_pub_t p, input logic [ADDR_W-1:0] addr);
        logic [SLOT_W-1:0] slot;
        slot = slotOf(addr);
        if (slot == SLOT_A) begin
            readOf = p.cfgA;
        end else if (slot == SLOT_B) begin
            readOf = p.cfgB;
        end else if (slot >= SLOT_BUF0 && slot != SLOT_NONE) begin
            readOf = p.bufView[slot - SLOT_BUF0];
        end else begin
            readOf = 8'h00;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // crossings
    // strap pin into the system domain
    spc_sync #(.W(1)) u_i2cSync (
        .clk(sys_clk),
        .rst_b(rst_b),
        .d(i2cMode),
        .q(i2cSync)
    );

    // write event toggle; the held word stays still until the next byte
    spc_sync #(.W(1)) u_wrSync (
        .clk(sys_clk),
        .rst_b(rst_b),
        .d(hold_r.wrToggle),
        .q(wrToggleSync)
    );

    // registered snapshot, changes only after a write that is long done or after the strap pin changes
    spc_sync #(.W($bits(spc_pub_t))) u_pubSync (
        .clk(spiClk),
        .rst_b(rst_b),
        .d(sys_r.pub),
        .q(pubSync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // reset sequencing
    assign softEff = sys_r.cfgA[A_SOFT_RST] & sys_r.cfgA[A_SOFT_RST_M];
    assign resetReq = softEff | sys_r.cfgB[B_KEEP_RST];

    spc_reset_seq #(.HOLD_CYC(HOLD_CYC)) u_resetSeq (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .startReq(resetReq),
        .busy(seqBusy),
        .done(seqDone)
    );

    ////////////////////////////////////////////////////////////////////////////
    // system domain register file
    always_comb begin
        logic newWrite;
        logic [SLOT_W-1:0] slot;
        spc_wr_word_t wr;
        newWrite = (wrToggleSync != sys_r.wrSeen);
        wr = hold_r.wrHold;
        slot = slotOf(wr.addr);
        sys_nxt = sys_r;
        sys_nxt.wrSeen = wrToggleSync;
        sys_nxt.updPulse = 1'b0;
        // kind of reset is fixed when the sequence starts
        if (!seqBusy) begin
            sys_nxt.fullRst = softEff;
        end
        // reset completion first, so a write in the same cycle wins
        if (seqDone) begin
            if (sys_r.fullRst) begin
                sys_nxt = sysDefaults(wrToggleSync);
            end else begin
                sys_nxt.cfgB[B_KEEP_RST] = 1'b0;
            end
        end
        if (newWrite) begin
            if (slot == SLOT_A) begin
                sys_nxt.cfgA = wr.data;
            end else if (slot == SLOT_B) begin
                sys_nxt.cfgB = wr.data & CFG_B_WR_MASK;
            end else if (slot == SLOT_UPD) begin
                // self-clearing: never stored, always reads zero
                if (wr.data[UPD_BIT]) begin
                    sys_nxt.bufActive = sys_r.bufShadow;
                    sys_nxt.updPulse = 1'b1;
                end
            end else if (slot != SLOT_NONE) begin
                sys_nxt.bufShadow[slot - SLOT_BUF0] = wr.data;
            end
        end
        // snapshot for the link side and the core
        sys_nxt.pub.mode = spc_mode_of(sys_r.cfgA, i2cSync);
        sys_nxt.pub.cfgA = sys_r.cfgA;
        sys_nxt.pub.cfgB = sys_r.cfgB;
        for (int i = 0; i < NUM_BUF; i++) begin
            // buffered copy or applied value on readback
            sys_nxt.pub.bufView[i] = sys_r.cfgB[B_READ_BUF] ? sys_r.bufShadow[i]
                                                             : sys_r.bufActive[i];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sys_r <= sysDefaults(1'b0);
        end else begin
            sys_r <= sys_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: instruction, address stepping and write capture
    always_comb begin
        logic [15:0] shiftIn;
        logic [15:0] instr;
        logic [7:0] byteIn;
        logic [ADDR_W-1:0] stepped;
        stepped = frame_r.addr;
        frame_nxt = frame_r;
        hold_nxt = hold_r;
        shiftIn = {frame_r.shift[14:0], sdioIn};
        instr = pubSync.mode.lsbFirst ? spc_rev16(shiftIn) : shiftIn;
        byteIn = pubSync.mode.lsbFirst ? spc_rev8(shiftIn[7:0]) : shiftIn[7:0];
        if (pubSync.mode.addrInc) begin
            stepped = frame_r.addr + 15'h0001;
        end else begin
            stepped = frame_r.addr - 15'h0001;
        end
        frame_nxt.shift = shiftIn;
        frame_nxt.bitCnt = frame_r.bitCnt + 5'h01;
        // the snapshot is stale for the first two edges of a frame, because the
        // serial clock stands still between frames; judge the mode at the decode
        if (!pubSync.mode.spiOn && frame_r.phase != PH_INSTR) begin
            // port is in I2C mode: frames are ignored here
            frame_nxt.phase = PH_OFF;
        end else begin
            case (frame_r.phase)
                PH_INSTR: begin
                    if (frame_r.bitCnt == 5'(INSTR_BITS - 1)) begin
                        frame_nxt.bitCnt = 5'h00;
                        frame_nxt.addr = instr[ADDR_W-1:0];
                        if (!pubSync.mode.spiOn) begin
                            frame_nxt.phase = PH_OFF;
                        end else begin
                            frame_nxt.phase = instr[RW_BIT] ? PH_READ : PH_WRITE;
                        end
                    end
                end
                PH_WRITE: begin
                    if (frame_r.bitCnt == 5'(BYTE_BITS - 1)) begin
                        frame_nxt.bitCnt = 5'h00;
                        frame_nxt.addr = stepped;
                        hold_nxt.wrHold.addr = frame_r.addr;
                        hold_nxt.wrHold.data = byteIn;
                        hold_nxt.wrToggle = ~hold_r.wrToggle;
                    end
                end
                PH_READ: begin
                    if (frame_r.bitCnt == 5'(BYTE_BITS - 1)) begin
                        frame_nxt.bitCnt = 5'h00;
                        frame_nxt.addr = stepped;
                    end
                end
                default: begin
                    frame_nxt.bitCnt = frame_r.bitCnt;
                end
            endcase
        end
    end

    // chip select high ends the frame even though the clock has stopped
    always_ff @(posedge spiClk or posedge chipSel_b) begin
        if (chipSel_b) begin
            frame_r <= '{phase: PH_INSTR, bitCnt: 5'h00, shift: 16'h0000, addr: 15'h0000};
        end else begin
            frame_r <= frame_nxt;
        end
    end

    // rst_b used asynchronously: the serial clock may be still during reset
    always_ff @(posedge spiClk or negedge rst_b) begin
        if (!rst_b) begin
            hold_r <= '0;
        end else begin
            hold_r <= hold_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // link domain: read data launched on the falling edge
    always_comb begin
        logic [7:0] rdByte;
        drive_nxt = drive_r;
        rdByte = readOf(pubSync, frame_r.addr);
        drive_nxt.driving = (frame_r.phase == PH_READ);
        if (frame_r.phase == PH_READ && frame_r.bitCnt == 5'h00) begin
            drive_nxt.outShift = pubSync.mode.lsbFirst ? spc_rev8(rdByte) : rdByte;
        end else begin
            drive_nxt.outShift = {drive_r.outShift[6:0], 1'b0};
        end
    end

    always_ff @(negedge spiClk or posedge chipSel_b) begin
        if (chipSel_b) begin
            drive_r <= '{outShift: 8'h00, driving: 1'b0};
        end else begin
            drive_r <= drive_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins and core outputs
    assign sdioOut = drive_r.outShift[7];
    assign sdoOut = drive_r.outShift[7];
    assign sdoOe = drive_r.driving & pubSync.mode.fourWire;
    assign sdioOe = drive_r.driving & ~pubSync.mode.fourWire;
    assign activeRegs = sys_r.bufActive;
    assign portMode = sys_r.pub.mode;
    assign coreRst = seqBusy;
    assign updateDone = sys_r.updPulse;
endmodule

// >>> spc_host_model.sv
// spc_host_model.sv - behavioural SPI host for the config block
// assumes the device samples on rising and drives on falling spiClk
`timescale 1ns/1ps
module spc_host_model (
    // link pins
    output logic spiClk,
    output logic chipSel_b,
    output logic sdioIn,
    // device drive
    input wire logic sdioOut,
    input wire logic sdioOe,
    input wire logic sdoOut,
    input wire logic sdoOe
);
    logic hostBit = 1'b0;
    logic lsb = 1'b0;
    logic four = 1'b0;
    logic [7:0] b [2];
    ////////////////////////////////////////
    // shared sdio wire; once released it shows the inverse of its last bit
    assign sdioIn = sdioOe ? sdioOut : hostBit;
    initial begin
        spiClk = 1'b0;
        chipSel_b = 1'b1;
    end
    // one bit: drive while low, take the answer at the rise
    // an undriven sdo line shows the inverse of the host bit
    task automatic bit1(input logic v, output logic s);
        hostBit = v;
        #7.5 spiClk = 1'b1;
        s = four ? (sdoOe ? sdoOut : ~v) : sdioIn;
        #7.5 spiClk = 1'b0;
    endtask
    // one frame; the clock stands still outside it
    task automatic xfer(input logic rd, input logic [14:0] a, input int n);
        logic [15:0] w;
        logic s;
        w = {rd, a};
        chipSel_b = 1'b0;
        for (int i = 0; i < 16; i++) bit1(w[lsb ? i : 15 - i], s);
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                bit1(b[k][lsb ? i : 7 - i], s);
                if (rd) b[k][lsb ? i : 7 - i] = s;
            end
        end
        hostBit = ~hostBit;
        #3 chipSel_b = 1'b1;
        #5;
    endtask
endmodule

// >>> spc_config_chk.sv
// spc_config_chk.sv - port assertions of the config block
// assumes everything is judged on sys_clk; link pins are seen as levels
`timescale 1ns/1ps
module spc_config_chk #(
    parameter int NUM_BUF = 4,
    parameter int HOLD_CYC = 20
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // link pins
    input wire logic chipSel_b,
    input wire logic sdioOe,
    input wire logic sdoOe,
    input wire logic i2cMode,
    // core side
    input wire logic [NUM_BUF-1:0][7:0] activeRegs,
    input wire spc_pkg::spc_port_mode_t portMode,
    input wire logic coreRst,
    input wire logic updateDone
);
    import spc_pkg::*;
    int rstCnt_r;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////
    // length of the current core reset, in cycles
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rstCnt_r <= 0;
        end else begin
            rstCnt_r <= coreRst ? rstCnt_r + 1 : 0;
        end
    end
    a_oe_exclusive: assert property (!(sdioOe && sdoOe))
        else $error("both data outputs driven");
    a_sdo_four_wire: assert property (sdoOe |-> portMode.fourWire)
        else $error("sdo driven outside 4-wire mode");
    a_sdio_three_wire: assert property (sdioOe |-> !portMode.fourWire)
        else $error("sdio driven in 4-wire mode");
    a_idle_no_drive: assert property (chipSel_b |-> !sdioOe && !sdoOe)
        else $error("data driven while deselected");
    a_i2c_modes_off: assert property (i2cMode [*4] |-> portMode == '0)
        else $error("spi controls active in i2c mode");
    a_spi_port_on: assert property (!i2cMode [*4] |-> portMode.spiOn)
        else $error("spi port off in spi mode");
    a_reset_length: assert property (!coreRst && $past(coreRst) |-> rstCnt_r == HOLD_CYC + 1)
        else $error("core reset pulse of wrong length");
    a_reset_bounded: assert property (coreRst |-> rstCnt_r <= HOLD_CYC)
        else $error("core reset does not end");
    a_update_pulse: assert property (updateDone |=> !updateDone)
        else $error("update pulse longer than a cycle");
    a_active_cause: assert property (!$stable(activeRegs) |-> updateDone || $past(coreRst))
        else $error("active registers changed without update");
    // main scenarios reached
    c_update: cover property (updateDone);
    c_core_rst: cover property ($fell(coreRst));
    c_four_wire: cover property (sdoOe);
endmodule

bind spc_config_top spc_config_chk #(.NUM_BUF(NUM_BUF), .HOLD_CYC(HOLD_CYC)) spc_config_chk_inst (
    .sys_clk(sys_clk), .rst_b(rst_b), .chipSel_b(chipSel_b), .sdioOe(sdioOe), .sdoOe(sdoOe),
    .i2cMode(i2cMode), .activeRegs(activeRegs), .portMode(portMode), .coreRst(coreRst),
    .updateDone(updateDone));

// >>> spc_config_top_test.sv
// spc_config_top_test.sv - self-checking bench of the config block
// assumes the host model drives the link; HOLD_CYC shortened to 2
`timescale 1ns/1ps
module spc_config_top_test;
    import spc_pkg::*;
    typedef struct {logic [14:0] wa; logic [7:0] wd; logic [14:0] ra; logic [7:0] ex;} spc_row_t;
    logic sys_clk, rst_b, i2cMode, spiClk, chipSel_b, sdioIn, sdioOut, sdioOe, sdoOut, sdoOe;
    logic coreRst, updateDone;
    logic [3:0][7:0] activeRegs;
    spc_port_mode_t portMode;
    int nFail = 0;
    int testsRun = 0;
    spc_row_t rows[6] = '{'{CFG_B_ADDR, 8'hdb, CFG_B_ADDR, 8'h00},
        '{15'h0003, 8'h5a, 15'h0003, 8'h00}, '{BUF_BASE_ADDR, 8'ha5, BUF_BASE_ADDR, 8'h00},
        '{CFG_B_ADDR, 8'h20, BUF_BASE_ADDR, 8'ha5}, '{UPDATE_ADDR, 8'h01, UPDATE_ADDR, 8'h00},
        '{CFG_B_ADDR, 8'h00, BUF_BASE_ADDR, 8'ha5}};
    spc_config_top #(.NUM_BUF(4), .HOLD_CYC(2)) spc_config_top_inst (.sys_clk(sys_clk),
        .rst_b(rst_b), .spiClk(spiClk), .chipSel_b(chipSel_b), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe), .i2cMode(i2cMode),
        .activeRegs(activeRegs), .portMode(portMode), .coreRst(coreRst), .updateDone(updateDone));
    spc_host_model spc_host_model_inst (.spiClk(spiClk), .chipSel_b(chipSel_b), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .sdoOut(sdoOut), .sdoOe(sdoOe));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nFail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrapUp();
        if (nFail == 0 && testsRun > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // inputs move 1 ns after the edge
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // long settle after writes: the write crosses into sys_clk and back
    task automatic wr(input logic [14:0] a, input logic [7:0] d0, input logic [7:0] d1,
            input int n);
        spc_host_model_inst.b[0] = d0;
        spc_host_model_inst.b[1] = d1;
        spc_host_model_inst.xfer(1'b0, a, n);
        idle(20);
    endtask
    task automatic rd2(input logic [14:0] a, input logic [7:0] e0, input logic [7:0] e1);
        spc_host_model_inst.xfer(1'b1, a, 2);
        chk("read byte 0", spc_host_model_inst.b[0], e0);
        chk("read byte 1", spc_host_model_inst.b[1], e1);
        idle(4);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // cut a hang short
    initial begin
        #100000;
        nFail++;
        wrapUp();
    end
    initial begin
        rst_b = 1'b0;
        i2cMode = 1'b0;
        idle(3);
        rst_b = 1'b1;
        idle(12);
        foreach (rows[i]) begin
            wr(rows[i].wa, rows[i].wd, 8'h00, 1);
            spc_host_model_inst.xfer(1'b1, rows[i].ra, 1);
            chk("row read", spc_host_model_inst.b[0], rows[i].ex);
            idle(4);
        end
        chk("active 0", activeRegs[0], 8'ha5);
        // default step is downwards
        wr(BUF_BASE_ADDR + 15'd1, 8'h11, 8'h22, 2);
        wr(UPDATE_ADDR, 8'h01, 8'h00, 1);
        rd2(BUF_BASE_ADDR + 15'd1, 8'h11, 8'h22);
        wr(CFG_A_ADDR, 8'h24, 8'h00, 1);
        wr(BUF_BASE_ADDR + 15'd2, 8'h33, 8'h44, 2);
        wr(UPDATE_ADDR, 8'h01, 8'h00, 1);
        rd2(BUF_BASE_ADDR + 15'd2, 8'h33, 8'h44);
        wr(CFG_A_ADDR, 8'h66, 8'h00, 1);
        spc_host_model_inst.lsb = 1'b1;
        rd2(BUF_BASE_ADDR + 15'd2, 8'h33, 8'h44);
        wr(CFG_A_ADDR, 8'h7e, 8'h00, 1);
        spc_host_model_inst.four = 1'b1;
        rd2(BUF_BASE_ADDR + 15'd2, 8'h33, 8'h44);
        // unmatched mirror leaves the pair off
        wr(CFG_A_ADDR, 8'h10, 8'h00, 1);
        spc_host_model_inst.lsb = 1'b0;
        spc_host_model_inst.four = 1'b0;
        chk("mode", {4'h0, portMode}, 8'h08);
        rd2(BUF_BASE_ADDR + 15'd2, 8'h33, 8'h11);
        wr(CFG_A_ADDR, 8'h80, 8'h00, 1);
        rd2(CFG_A_ADDR, 8'h80, 8'h00);
        wr(CFG_B_ADDR, 8'h04, 8'h00, 1);
        rd2(CFG_B_ADDR, 8'h00, 8'h80);
        chk("kept active", activeRegs[2], 8'h33);
        wr(CFG_A_ADDR, 8'h81, 8'h00, 1);
        rd2(CFG_B_ADDR, 8'h00, 8'h00);
        chk("cleared active", activeRegs[2], 8'h00);
        i2cMode = 1'b1;
        idle(6);
        chk("i2c mode", {4'h0, portMode}, 8'h00);
        wr(CFG_A_ADDR, 8'h24, 8'h00, 1);
        i2cMode = 1'b0;
        idle(6);
        // a write taken in i2c mode would show in configuration A
        rd2(CFG_A_ADDR, 8'h00, 8'h00);
        wrapUp();
    end
endmodule
